// file: hdl/tpmr_defs.svh
// Constants of the three-port memory: sizes and reset/clear values.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef TPMR_DEFS_SVH
`define TPMR_DEFS_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define TPMR_ADDR_W 6
`define TPMR_DATA_W 18
`define TPMR_NUM_RD_PORTS 2

// ---------------------------------------------------------------
// Reset and clear values
// ---------------------------------------------------------------
`define TPMR_ADDR_RST '0
`define TPMR_SEL_RST 1'b0
`define TPMR_DOUT_RST '0
`define TPMR_IDLE_DATA '0
`define TPMR_SYNC_RST '0

`endif

// file: hdl/tpmr_pkg.sv
// Types shared by the three-port memory and its read-port module.
// Assumes nothing of its surroundings.
package tpmr_pkg;

  // ---------------------------------------------------------------
  // Per read port control pins, after synchronisation
  // ---------------------------------------------------------------
  typedef struct packed {
    logic addr_clk;
    logic sel;
    logic addr_en;
    logic addr_sclr_n;
    logic pipe_clk;
    logic pipe_en;
    logic pipe_sclr_n;
  } tpmr_rd_ctrl_t;

  // ---------------------------------------------------------------
  // Write port control pins
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr_clk;
    logic wen;
    logic sel;
  } tpmr_wr_ctrl_t;

endpackage

// file: hdl/tpmr_rd_if.sv
// Link between the memory core and one read port.
// Assumes the core owns the array and the pin synchronisers.
`timescale 1ns/100ps
`include "tpmr_defs.svh"

interface tpmr_rd_if #(
  parameter int ADDR_W = `TPMR_ADDR_W,
  parameter int DATA_W = `TPMR_DATA_W
);
  tpmr_pkg::tpmr_rd_ctrl_t ctrl;
  logic [ADDR_W-1:0] addr;
  logic addr_aclr_n;
  logic pipe_aclr_n;
  logic [ADDR_W-1:0] arr_addr;
  logic arr_sel;
  logic [DATA_W-1:0] arr_data;
  logic [DATA_W-1:0] dout;

  modport port (
    input ctrl, addr, addr_aclr_n, pipe_aclr_n, arr_data,
    output arr_addr, arr_sel, dout
  );
  modport core (
    output ctrl, addr, addr_aclr_n, pipe_aclr_n, arr_data,
    input arr_addr, arr_sel, dout
  );
endinterface

// file: hdl/tpmr_rd_port.sv
// One read port: address/select register and output pipeline register.
// Assumes synchronised control and address from the core; raw async clears.
`timescale 1ns/100ps
`include "tpmr_defs.svh"

module tpmr_rd_port #(
  parameter int ADDR_W = `TPMR_ADDR_W,
  parameter int DATA_W = `TPMR_DATA_W
) (
  input logic clock,
  input logic rst_n,
  tpmr_rd_if.port rd
);

  logic addr_clk_prev_q;
  logic pipe_clk_prev_q;
  logic addr_edge;
  logic pipe_edge;
  logic [ADDR_W-1:0] addr_q;
  logic sel_q;
  logic [DATA_W-1:0] dout_q;

  // ---------------------------------------------------------------
  // Edges of the sampled port clocks
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_clk_prev_q <= 1'b0;
      pipe_clk_prev_q <= 1'b0;
    end else begin
      addr_clk_prev_q <= rd.ctrl.addr_clk;
      pipe_clk_prev_q <= rd.ctrl.pipe_clk;
    end
  end

  assign addr_edge = rd.ctrl.addr_clk & ~addr_clk_prev_q;
  assign pipe_edge = rd.ctrl.pipe_clk & ~pipe_clk_prev_q;

  // ---------------------------------------------------------------
  // Address and select register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n or negedge rd.addr_aclr_n) begin
    if (!rst_n || !rd.addr_aclr_n) begin
      addr_q <= `TPMR_ADDR_RST;
      sel_q <= `TPMR_SEL_RST;
    end else if (addr_edge) begin
      if (!rd.ctrl.addr_sclr_n) begin
        addr_q <= `TPMR_ADDR_RST;
        sel_q <= `TPMR_SEL_RST;
      end else if (rd.ctrl.addr_en) begin
        addr_q <= rd.addr;
        sel_q <= rd.ctrl.sel;
      end
    end
  end

  assign rd.arr_addr = addr_q;
  assign rd.arr_sel = sel_q;

  // ---------------------------------------------------------------
  // Output pipeline register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n or negedge rd.pipe_aclr_n) begin
    if (!rst_n || !rd.pipe_aclr_n) begin
      dout_q <= `TPMR_DOUT_RST;
    end else if (pipe_edge) begin
      if (!rd.ctrl.pipe_sclr_n) begin
        dout_q <= `TPMR_DOUT_RST;
      end else if (rd.ctrl.pipe_en) begin
        dout_q <= rd.arr_data;
      end
    end
  end

  assign rd.dout = dout_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_addr_load;
    addr_edge && rd.ctrl.addr_sclr_n && rd.ctrl.addr_en && rd.addr_aclr_n;
  endsequence
  sequence s_pipe_load;
    pipe_edge && rd.ctrl.pipe_sclr_n && rd.ctrl.pipe_en && rd.pipe_aclr_n;
  endsequence

  a_addr_capture: assert property (s_addr_load ##1 rd.addr_aclr_n |->
    addr_q == $past(rd.addr) && sel_q == $past(rd.ctrl.sel))
    else $error("address register missed its load");
  a_addr_hold: assert property ((!addr_edge || !rd.ctrl.addr_en) && rd.ctrl.addr_sclr_n
    ##1 rd.addr_aclr_n |-> $stable(addr_q) && $stable(sel_q))
    else $error("address register changed without enable");
  a_addr_sync_clr: assert property (addr_edge && !rd.ctrl.addr_sclr_n |=>
    addr_q == '0 && !sel_q)
    else $error("address sync clear failed");
  a_addr_async_clr: assert property (!rd.addr_aclr_n |-> addr_q == '0 && !sel_q)
    else $error("address async clear failed");
  a_pipe_capture: assert property (s_pipe_load ##1 rd.pipe_aclr_n |->
    dout_q == $past(rd.arr_data))
    else $error("pipeline register missed its load");
  a_pipe_hold: assert property ((!pipe_edge || !rd.ctrl.pipe_en) && rd.ctrl.pipe_sclr_n
    ##1 rd.pipe_aclr_n |-> $stable(dout_q))
    else $error("pipeline register changed without enable");
  a_pipe_sync_clr: assert property (pipe_edge && !rd.ctrl.pipe_sclr_n |=>
    dout_q == '0)
    else $error("pipeline sync clear failed");
  a_pipe_async_clr: assert property (!rd.pipe_aclr_n |-> dout_q == '0)
    else $error("pipeline async clear failed");
  a_sel_gates: assert property (!sel_q |-> rd.arr_data == '0)
    else $error("deselected port shows data");

endmodule

// file: hdl/tpmr_three_port_ram.sv
// Three-port memory: two read ports with registered address and output,
// one write port. All port clocks arrive as pins and are sampled.
// Assumes port clocks and data pins toggle slower than clock / 4.
//
// Summary of operation
// - Two reads of one location return the same stored word independently.
// - First read during write to same word: write correct, read undefined.
// - Second read during write to same word: write correct, read undefined.
// - Both reads during write to same word: write correct, reads undefined.
// - Address register loads on the port's address clock rising edge.
// - Address register loads only while its enable is high.
// - Address register clears at its clock edge when sync clear is low.
// - Address register clears at once while async clear is low.
// - Pipeline register loads read data on the port's output clock edge.
// - Pipeline register loads only while its enable is high.
// - Pipeline register clears at its clock edge when sync clear is low.
// - Pipeline register clears at once while async clear is low.
// - Write port samples address and data on its clock rising edge.
// - Only the write port modifies the array.
// - A valid write completes within one write-clock cycle.
// - Address reset clears address and select, forcing read data to zero.
`timescale 1ns/100ps
`include "tpmr_defs.svh"

module tpmr_three_port_ram #(
  parameter int ADDR_W = `TPMR_ADDR_W,
  parameter int DATA_W = `TPMR_DATA_W
) (
  input logic clock,
  input logic rst_n,
  input logic [ADDR_W-1:0] first_read_port_addr,
  input logic first_read_port_select,
  input logic first_read_port_address_clk,
  input logic first_read_port_address_en,
  input logic first_read_port_address_sync_clear_n,
  input logic first_read_port_address_async_clear_n,
  input logic first_read_port_pipe_clk,
  input logic first_read_port_pipe_en,
  input logic first_read_port_pipe_sync_clear_n,
  input logic first_read_port_pipe_async_clear_n,
  output logic [DATA_W-1:0] first_read_port_dout,
  input logic [ADDR_W-1:0] second_read_port_addr,
  input logic second_read_port_select,
  input logic second_read_port_address_clk,
  input logic second_read_port_address_en,
  input logic second_read_port_address_sync_clear_n,
  input logic second_read_port_address_async_clear_n,
  input logic second_read_port_pipe_clk,
  input logic second_read_port_pipe_en,
  input logic second_read_port_pipe_sync_clear_n,
  input logic second_read_port_pipe_async_clear_n,
  output logic [DATA_W-1:0] second_read_port_dout,
  input logic [ADDR_W-1:0] write_port_addr,
  input logic [DATA_W-1:0] write_port_data,
  input logic write_port_clk,
  input logic write_port_wen,
  input logic write_port_select
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int NPORT = `TPMR_NUM_RD_PORTS;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];

  // ---------------------------------------------------------------
  // Read port pins gathered per port
  // ---------------------------------------------------------------
  tpmr_pkg::tpmr_rd_ctrl_t rd_ctrl_raw [NPORT];
  logic [ADDR_W-1:0] rd_addr_raw [NPORT];
  logic rd_addr_aclr_n [NPORT];
  logic rd_pipe_aclr_n [NPORT];

  assign rd_ctrl_raw[0] = '{
    addr_clk: first_read_port_address_clk,
    sel: first_read_port_select,
    addr_en: first_read_port_address_en,
    addr_sclr_n: first_read_port_address_sync_clear_n,
    pipe_clk: first_read_port_pipe_clk,
    pipe_en: first_read_port_pipe_en,
    pipe_sclr_n: first_read_port_pipe_sync_clear_n
  };
  assign rd_ctrl_raw[1] = '{
    addr_clk: second_read_port_address_clk,
    sel: second_read_port_select,
    addr_en: second_read_port_address_en,
    addr_sclr_n: second_read_port_address_sync_clear_n,
    pipe_clk: second_read_port_pipe_clk,
    pipe_en: second_read_port_pipe_en,
    pipe_sclr_n: second_read_port_pipe_sync_clear_n
  };
  assign rd_addr_raw[0] = first_read_port_addr;
  assign rd_addr_raw[1] = second_read_port_addr;
  assign rd_addr_aclr_n[0] = first_read_port_address_async_clear_n;
  assign rd_addr_aclr_n[1] = second_read_port_address_async_clear_n;
  assign rd_pipe_aclr_n[0] = first_read_port_pipe_async_clear_n;
  assign rd_pipe_aclr_n[1] = second_read_port_pipe_async_clear_n;

  // ---------------------------------------------------------------
  // Read ports: synchroniser, array read, port registers
  // ---------------------------------------------------------------
  for (genvar p = 0; p < NPORT; p++) begin : g_rd
    tpmr_pkg::tpmr_rd_ctrl_t ctrl_s1_q;
    tpmr_pkg::tpmr_rd_ctrl_t ctrl_s2_q;
    logic [ADDR_W-1:0] addr_s1_q;
    logic [ADDR_W-1:0] addr_s2_q;

    tpmr_rd_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) rd_if ();

    // Control and address share one delay so they stay aligned
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_s1_q <= `TPMR_SYNC_RST;
        ctrl_s2_q <= `TPMR_SYNC_RST;
        addr_s1_q <= `TPMR_SYNC_RST;
        addr_s2_q <= `TPMR_SYNC_RST;
      end else begin
        ctrl_s1_q <= rd_ctrl_raw[p];
        ctrl_s2_q <= ctrl_s1_q;
        addr_s1_q <= rd_addr_raw[p];
        addr_s2_q <= addr_s1_q;
      end
    end

    assign rd_if.ctrl = ctrl_s2_q;
    assign rd_if.addr = addr_s2_q;
    assign rd_if.addr_aclr_n = rd_addr_aclr_n[p];
    assign rd_if.pipe_aclr_n = rd_pipe_aclr_n[p];

    // Ports read the array independently; deselect forces zero
    assign rd_if.arr_data = rd_if.arr_sel ? mem[rd_if.arr_addr]
                                          : `TPMR_IDLE_DATA;

    tpmr_rd_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_port (
      .clock(clock),
      .rst_n(rst_n),
      .rd(rd_if.port)
    );
  end

  assign first_read_port_dout = g_rd[0].rd_if.dout;
  assign second_read_port_dout = g_rd[1].rd_if.dout;

  // ---------------------------------------------------------------
  // Write port synchroniser
  // ---------------------------------------------------------------
  tpmr_pkg::tpmr_wr_ctrl_t wr_ctrl_s1_q;
  tpmr_pkg::tpmr_wr_ctrl_t wr_ctrl_s2_q;
  logic [ADDR_W-1:0] wr_addr_s1_q;
  logic [ADDR_W-1:0] wr_addr_s2_q;
  logic [DATA_W-1:0] wr_data_s1_q;
  logic [DATA_W-1:0] wr_data_s2_q;
  logic wr_clk_prev_q;
  logic wr_edge;
  logic wr_fire;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ctrl_s1_q <= `TPMR_SYNC_RST;
      wr_ctrl_s2_q <= `TPMR_SYNC_RST;
      wr_addr_s1_q <= `TPMR_SYNC_RST;
      wr_addr_s2_q <= `TPMR_SYNC_RST;
      wr_data_s1_q <= `TPMR_SYNC_RST;
      wr_data_s2_q <= `TPMR_SYNC_RST;
    end else begin
      wr_ctrl_s1_q <= '{wr_clk: write_port_clk, wen: write_port_wen, sel: write_port_select};
      wr_ctrl_s2_q <= wr_ctrl_s1_q;
      wr_addr_s1_q <= write_port_addr;
      wr_addr_s2_q <= wr_addr_s1_q;
      wr_data_s1_q <= write_port_data;
      wr_data_s2_q <= wr_data_s1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_clk_prev_q <= 1'b0;
    end else begin
      wr_clk_prev_q <= wr_ctrl_s2_q.wr_clk;
    end
  end

  // ---------------------------------------------------------------
  // Array write
  // ---------------------------------------------------------------
  assign wr_edge = wr_ctrl_s2_q.wr_clk & ~wr_clk_prev_q;
  assign wr_fire = wr_edge & wr_ctrl_s2_q.wen & wr_ctrl_s2_q.sel;

  // Sole writer of the array; reads never disturb it, no collision guard
  always_ff @(posedge clock) begin
    if (wr_fire) begin
      mem[wr_addr_s2_q] <= wr_data_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_write;
    wr_fire;
  endsequence
  sequence s_write_blocked;
    wr_edge && !(wr_ctrl_s2_q.wen && wr_ctrl_s2_q.sel);
  endsequence

  a_write_done: assert property (s_write |=>
    mem[$past(wr_addr_s2_q)] == $past(wr_data_s2_q))
    else $error("write not in array one cycle later");
  a_write_gated: assert property (s_write_blocked |=>
    mem[$past(wr_addr_s2_q)] == $past(mem[wr_addr_s2_q]))
    else $error("array changed without select and enable");
  a_no_write_idle: assert property (!wr_fire ##1
    $stable(g_rd[0].rd_if.arr_addr) && $stable(g_rd[0].rd_if.arr_sel) |->
    $stable(g_rd[0].rd_if.arr_data))
    else $error("first read word changed without a write");
  a_second_word_stable: assert property (!wr_fire ##1
    $stable(g_rd[1].rd_if.arr_addr) && $stable(g_rd[1].rd_if.arr_sel) |->
    $stable(g_rd[1].rd_if.arr_data))
    else $error("second read word changed without a write");
  a_ports_agree: assert property (g_rd[0].rd_if.arr_sel && g_rd[1].rd_if.arr_sel &&
    g_rd[0].rd_if.arr_addr == g_rd[1].rd_if.arr_addr |->
    g_rd[0].rd_if.arr_data == g_rd[1].rd_if.arr_data)
    else $error("read ports disagree on one location");
  a_collide_first: assert property ((s_write and (g_rd[0].rd_if.arr_sel &&
    g_rd[0].rd_if.arr_addr == wr_addr_s2_q)) ##1
    $stable(g_rd[0].rd_if.arr_addr) && g_rd[0].rd_if.arr_sel |->
    g_rd[0].rd_if.arr_data == $past(wr_data_s2_q))
    else $error("first port misses new data after collision");
  a_collide_second: assert property ((s_write and (g_rd[1].rd_if.arr_sel &&
    g_rd[1].rd_if.arr_addr == wr_addr_s2_q)) ##1
    $stable(g_rd[1].rd_if.arr_addr) && g_rd[1].rd_if.arr_sel |->
    g_rd[1].rd_if.arr_data == $past(wr_data_s2_q))
    else $error("second port misses new data after collision");
  a_collide_both: assert property ((s_write and (g_rd[0].rd_if.arr_sel &&
    g_rd[1].rd_if.arr_sel && g_rd[0].rd_if.arr_addr == wr_addr_s2_q &&
    g_rd[1].rd_if.arr_addr == wr_addr_s2_q)) ##1
    $stable(g_rd[0].rd_if.arr_addr) && $stable(g_rd[1].rd_if.arr_addr) |->
    mem[$past(wr_addr_s2_q)] == $past(wr_data_s2_q))
    else $error("triple collision broke the write");
  a_dout_clear: assert property (!first_read_port_pipe_async_clear_n |->
    first_read_port_dout == '0)
    else $error("first output not cleared");
  a_dout_clear_second: assert property (!second_read_port_pipe_async_clear_n |->
    second_read_port_dout == '0)
    else $error("second output not cleared");

  // Pin level: a pin clock rise acts at the second edge after it is first seen
  sequence s_pin_write;
    !write_port_clk ##1 write_port_clk;
  endsequence
  sequence s_pin_addr_first;
    !first_read_port_address_clk ##1 (first_read_port_address_clk &&
      first_read_port_address_en && first_read_port_address_sync_clear_n);
  endsequence
  sequence s_pin_addr_second;
    !second_read_port_address_clk ##1 (second_read_port_address_clk &&
      second_read_port_address_en && second_read_port_address_sync_clear_n);
  endsequence
  sequence s_pin_pipe_first;
    !first_read_port_pipe_clk ##1 (first_read_port_pipe_clk &&
      first_read_port_pipe_en && first_read_port_pipe_sync_clear_n);
  endsequence
  sequence s_pin_pipe_second;
    !second_read_port_pipe_clk ##1 (second_read_port_pipe_clk &&
      second_read_port_pipe_en && second_read_port_pipe_sync_clear_n);
  endsequence

  a_pin_write_fire: assert property (s_pin_write |->
    ##2 (wr_fire == $past(write_port_wen && write_port_select, 2)))
    else $error("write pin edge not acted on two edges later");
  a_pin_write_data: assert property (s_pin_write ##0
    (write_port_wen && write_port_select) |->
    ##3 (mem[$past(write_port_addr, 3)] == $past(write_port_data, 3)))
    else $error("write pin data not in array three edges later");
  a_pin_addr_first: assert property (s_pin_addr_first ##2
    first_read_port_address_async_clear_n ##1 first_read_port_address_async_clear_n |->
    g_rd[0].rd_if.arr_addr == $past(first_read_port_addr, 3) &&
    g_rd[0].rd_if.arr_sel == $past(first_read_port_select, 3))
    else $error("first address pin not loaded three edges later");
  a_pin_addr_second: assert property (s_pin_addr_second ##2
    second_read_port_address_async_clear_n ##1 second_read_port_address_async_clear_n |->
    g_rd[1].rd_if.arr_addr == $past(second_read_port_addr, 3) &&
    g_rd[1].rd_if.arr_sel == $past(second_read_port_select, 3))
    else $error("second address pin not loaded three edges later");
  a_pin_pipe_first: assert property (s_pin_pipe_first ##2
    first_read_port_pipe_async_clear_n ##1 first_read_port_pipe_async_clear_n |->
    first_read_port_dout == $past(g_rd[0].rd_if.arr_data))
    else $error("first pipeline pin edge not loaded");
  a_pin_pipe_second: assert property (s_pin_pipe_second ##2
    second_read_port_pipe_async_clear_n ##1 second_read_port_pipe_async_clear_n |->
    second_read_port_dout == $past(g_rd[1].rd_if.arr_data))
    else $error("second pipeline pin edge not loaded");
  a_addr_clear_first: assert property (!first_read_port_address_async_clear_n |->
    g_rd[0].rd_if.arr_data == '0)
    else $error("first read path not zero under address clear");
  a_addr_clear_second: assert property (!second_read_port_address_async_clear_n |->
    g_rd[1].rd_if.arr_data == '0)
    else $error("second read path not zero under address clear");

endmodule

// file: tb/tpmr_user_model.sv
// Pin-level model of the fabric logic that drives the three-port memory.
// Assumes one caller at a time; every pin changes at a falling clock edge.
`timescale 1ns/100ps
`include "tpmr_defs.svh"

module tpmr_user_model (
  input wire logic clock,
  output tpmr_pkg::tpmr_rd_ctrl_t rc [2],
  output logic [`TPMR_ADDR_W-1:0] ra [2],
  output logic [1:0] aclr_n,
  output logic [1:0] pclr_n,
  output tpmr_pkg::tpmr_wr_ctrl_t wc,
  output logic [`TPMR_ADDR_W-1:0] wa,
  output logic [`TPMR_DATA_W-1:0] wd
);
  // Clocks low, clears released
  initial begin
    rc[0] = 7'h09;
    rc[1] = 7'h09;
    ra[0] = '0;
    ra[1] = '0;
    aclr_n = 2'h3;
    pclr_n = 2'h3;
    wc = 3'h0;
    wa = '0;
    wd = '0;
  end

  task automatic set_rd(input int p, input logic [`TPMR_ADDR_W-1:0] a, input logic s,
                        input logic [3:0] en);
    @(negedge clock);
    ra[p] = a;
    rc[p].sel = s;
    {rc[p].addr_en, rc[p].addr_sclr_n, rc[p].pipe_en, rc[p].pipe_sclr_n} = en;
    repeat (2) @(negedge clock);
  endtask

  task automatic set_wr(input logic [`TPMR_ADDR_W-1:0] a, input logic [`TPMR_DATA_W-1:0] d,
                        input logic en, input logic s);
    @(negedge clock);
    wa = a;
    wd = d;
    wc.wen = en;
    wc.sel = s;
    repeat (2) @(negedge clock);
  endtask

  // Mask: address clocks, pipe clocks, write clock; three cycles high
  // Reads meet a write on one word only when a caller merges them
  task automatic pulse(input logic [4:0] m);
    for (int v = 1; v >= 0; v--) begin
      @(negedge clock);
      rc[0].addr_clk = m[0] & v[0];
      rc[1].addr_clk = m[1] & v[0];
      rc[0].pipe_clk = m[2] & v[0];
      rc[1].pipe_clk = m[3] & v[0];
      wc.wr_clk = m[4] & v[0];
      repeat (2) @(negedge clock);
    end
  endtask

  task automatic hold_clr(input int p, input logic pipe, input logic v);
    @(negedge clock);
    if (pipe)
      pclr_n[p] = v;
    else
      aclr_n[p] = v;
  endtask
endmodule

// file: tb/three_port_micro_ram_tb.sv
// Self-checking bench of the three-port memory with random pin traffic.
// Assumes the user model drives all pins; a word model predicts each dout.
`timescale 1ns/100ps
`include "tpmr_defs.svh"

module three_port_micro_ram_tb;
  localparam int AW = `TPMR_ADDR_W;
  localparam int DW = `TPMR_DATA_W;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  tpmr_pkg::tpmr_rd_ctrl_t rc [2];
  logic [AW-1:0] ra [2];
  logic [1:0] aclr_n;
  logic [1:0] pclr_n;
  tpmr_pkg::tpmr_wr_ctrl_t wc;
  logic [AW-1:0] wa;
  logic [DW-1:0] wd;
  wire logic [DW-1:0] dout [2];
  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] cur_a [2] = '{default: '0};
  logic cur_s [2] = '{default: 1'b0};
  logic [DW-1:0] exp_d [2] = '{default: '0};
  logic [31:0] seed = 32'h0000004e;
  logic [31:0] r;
  logic [31:0] e;
  logic [1:0] k;
  int p;
  int num_errors = 0;
  int n_checks = 0;

  always #12.5 clock = ~clock;

  tpmr_user_model i_user (.clock(clock), .rc(rc), .ra(ra), .aclr_n(aclr_n),
    .pclr_n(pclr_n), .wc(wc), .wa(wa), .wd(wd));

  tpmr_three_port_ram i_dut (
    .clock(clock),
    .rst_n(rst_n),
    .first_read_port_addr(ra[0]),
    .first_read_port_select(rc[0].sel),
    .first_read_port_address_clk(rc[0].addr_clk),
    .first_read_port_address_en(rc[0].addr_en),
    .first_read_port_address_sync_clear_n(rc[0].addr_sclr_n),
    .first_read_port_address_async_clear_n(aclr_n[0]),
    .first_read_port_pipe_clk(rc[0].pipe_clk),
    .first_read_port_pipe_en(rc[0].pipe_en),
    .first_read_port_pipe_sync_clear_n(rc[0].pipe_sclr_n),
    .first_read_port_pipe_async_clear_n(pclr_n[0]),
    .first_read_port_dout(dout[0]),
    .second_read_port_addr(ra[1]),
    .second_read_port_select(rc[1].sel),
    .second_read_port_address_clk(rc[1].addr_clk),
    .second_read_port_address_en(rc[1].addr_en),
    .second_read_port_address_sync_clear_n(rc[1].addr_sclr_n),
    .second_read_port_address_async_clear_n(aclr_n[1]),
    .second_read_port_pipe_clk(rc[1].pipe_clk),
    .second_read_port_pipe_en(rc[1].pipe_en),
    .second_read_port_pipe_sync_clear_n(rc[1].pipe_sclr_n),
    .second_read_port_pipe_async_clear_n(pclr_n[1]),
    .second_read_port_dout(dout[1]),
    .write_port_addr(wa),
    .write_port_data(wd),
    .write_port_clk(wc.wr_clk),
    .write_port_wen(wc.wen),
    .write_port_select(wc.sel)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected dout at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pulses pin clocks, then advances the word model: write, address, pipe
  task automatic fire(input logic [4:0] m);
    i_user.pulse(m);
    if (m[4] && wc.wen && wc.sel)
      mem[wa] = wd;
    for (int q = 0; q < 2; q++) begin
      if (m[q] && !rc[q].addr_sclr_n) begin
        cur_a[q] = '0;
        cur_s[q] = 1'b0;
      end else if (m[q] && rc[q].addr_en) begin
        cur_a[q] = ra[q];
        cur_s[q] = rc[q].sel;
      end
      if (m[q+2] && !rc[q].pipe_sclr_n)
        exp_d[q] = '0;
      else if (m[q+2] && rc[q].pipe_en)
        exp_d[q] = cur_s[q] ? mem[cur_a[q]] : '0;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, n_checks, 0);
    summarize();
  end

  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 2**AW; i++) begin
      r = rnd();
      i_user.set_wr(i[AW-1:0], r[31:14], 1'b1, 1'b1);
      fire(5'h10);
    end
    for (int i = 0; i < 120; i++) begin
      r = rnd();
      p = int'(r[11]);
      k = (r[13:12] == 2'h0) ? 2'h3 : r[13:12];
      if (r[10:8] < 3'h2) begin
        i_user.set_wr(r[5:0], r[31:14], r[6] | r[7], r[6] | r[11]);
        fire(5'h10);
      end else if (r[10:8] == 3'h2) begin
        i_user.hold_clr(p, r[12], 1'b0);
        #2;
        if (r[12])
          exp_d[p] = '0;
        else begin
          cur_a[p] = '0;
          cur_s[p] = 1'b0;
        end
        check(dout[p], exp_d[p]);
        i_user.hold_clr(p, r[12], 1'b1);
      end else begin
        for (int q = 0; q < 2; q++) begin
          e = rnd();
          if (k[q])
            i_user.set_rd(q, r[5:0], e[0] | e[1], {e[2] | e[3], e[4] | e[5], e[6] | e[7], e[8]});
        end
        fire({3'h0, k});
        fire({1'b0, k, 2'h0});
        for (int q = 0; q < 2; q++) begin
          if (k[q])
            check(dout[q], exp_d[q]);
        end
      end
    end
    for (int c = 1; c < 4; c++) begin
      r = rnd();
      i_user.set_wr(r[5:0], r[31:14], 1'b1, 1'b1);
      for (int q = 0; q < 2; q++)
        i_user.set_rd(q, r[5:0], 1'b1, 4'hf);
      fire({3'h4, c[1:0]});
      fire({1'b0, c[1:0], 2'h0});
      for (int q = 0; q < 2; q++) begin
        if (c[q])
          check(dout[q], exp_d[q]);
      end
      // Second write while the address registers of the ports in c already hold that word
      i_user.set_wr(r[5:0], ~r[31:14], 1'b1, 1'b1);
      fire(5'h10);
      fire({1'b0, c[1:0], 2'h0});
      for (int q = 0; q < 2; q++) begin
        if (c[q])
          check(dout[q], exp_d[q]);
      end
    end
    summarize();
  end
endmodule
